// File: src/tpucc_pkg.sv
// constants, field layout and helper functions for the timer clock and clear control
package tpucc_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int NCH = 4;
  localparam int NGR = 4;
  localparam int CNT_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int DIV_W = 6;

  // ****************************************
  // address map: channel c, word i at (c << CH_LSB) | (i << IDX_LSB)
  // ****************************************
  localparam int REGION_LSB = 7;
  localparam int CH_LSB = 5;
  localparam int IDX_LSB = 2;
  localparam logic [ADDR_W-1:0] RUN_ADDR = 12'h080;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_MODE = 3'h1;
  localparam logic [2:0] IDX_IOC = 3'h2;
  localparam logic [2:0] IDX_CNT = 3'h3;

  // ****************************************
  // count control field layout and codes
  // ****************************************
  localparam int CTRL_IMPL_W = 8;
  localparam int CLR_LSB = 5;
  localparam int EDGE_LSB = 3;
  localparam int PSC_LSB = 0;
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam int EDGE_BOTH_BIT = 1;
  localparam logic [2:0] PSC_1 = 3'h0;
  localparam logic [2:0] PSC_4 = 3'h1;
  localparam logic [2:0] PSC_16 = 3'h2;
  localparam logic [2:0] PSC_64 = 3'h3;
  localparam int TAP_4 = 1;
  localparam int TAP_16 = 3;
  localparam int TAP_64 = 5;

  // ****************************************
  // operating mode and pin action
  // ****************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam int ACT_LVL_BIT = 2;
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_ZERO = 2'h1;
  localparam logic [1:0] ACT_ONE = 2'h2;
  localparam logic [2:0] PWM_OK_LO = 3'h2;
  localparam logic [2:0] PWM_OK_HI = 3'h5;

  // one count enable for a channel, from the shared free-running divider
  function automatic logic tpucc_tick(input logic [2:0] psc, input logic [1:0] edg,
                                      input logic [DIV_W-1:0] div);
    logic [DIV_W-1:0] nxt;
    int tap;
    logic rise;
    logic fall;
    nxt = div + 1'b1;
    tap = TAP_4;
    case (psc)
      PSC_4: tap = TAP_4;
      PSC_16: tap = TAP_16;
      PSC_64: tap = TAP_64;
      default: tap = TAP_4;
    endcase
    rise = !div[tap] && nxt[tap];
    fall = div[tap] && !nxt[tap];
    if (psc == PSC_1) begin
      // undivided clock: one count per cycle whatever the edge code
      tpucc_tick = 1'b1;
    end else if (psc > PSC_64) begin
      tpucc_tick = 1'b0;
    end else if (edg[EDGE_BOTH_BIT]) begin
      tpucc_tick = rise || fall;
    end else if (edg == EDGE_FALL) begin
      tpucc_tick = fall;
    end else begin
      tpucc_tick = rise;
    end
  endfunction : tpucc_tick

  // byte-lane merge for a 16-bit register
  function automatic logic [CNT_W-1:0] tpucc_merge16(input logic [CNT_W-1:0] old,
                                                     input logic [DATA_W-1:0] wd,
                                                     input logic [3:0] strb);
    tpucc_merge16 = old;
    if (strb[0]) begin
      tpucc_merge16[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      tpucc_merge16[15:8] = wd[15:8];
    end
  endfunction : tpucc_merge16

endpackage : tpucc_pkg

// File: src/tpucc_ch_if.sv
// settings and state passed between the register file and one timer channel
interface tpucc_ch_if;
  import tpucc_pkg::*;
  logic run;
  logic tick;
  logic [2:0] clr_sel;
  logic [2:0] mode;
  logic [2:0] ioa;
  logic [CNT_W-1:0] gr [NGR];
  logic [CNT_W-1:0] cnt;
  logic wave;

  modport regs (output run, tick, clr_sel, mode, ioa, gr, input cnt, wave);
  modport chan (input run, tick, clr_sel, mode, ioa, gr, output cnt, wave);
endinterface : tpucc_ch_if

// File: src/tpucc_chan.sv
// one timer channel: counter, compare clear and wave output
module tpucc_chan (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // settings and state
  tpucc_ch_if.chan ch
);
  import tpucc_pkg::*;

  // ****************************************
  // compare and clear decode
  // ****************************************
  logic [CNT_W-1:0] cnt_ff;
  logic wave_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic nxt_wave;
  wire step = ch.run && ch.tick;
  wire [NGR-1:0] match;
  for (genvar i = 0; i < NGR; i++) begin : g_cmp
    assign match[i] = step && (cnt_ff == ch.gr[i]);
  end
  wire clr_hit = (ch.clr_sel == CLR_A && match[0])
              || (ch.clr_sel == CLR_B && match[1])
              || (ch.clr_sel == CLR_C && match[2])
              || (ch.clr_sel == CLR_D && match[3]);  // other codes never clear
  wire lvl = ch.ioa[ACT_LVL_BIT];
  wire pwm = ch.mode == MODE_PWM;  // prohibited codes behave as normal
  wire pwm_ok = ch.ioa == PWM_OK_LO || ch.ioa == PWM_OK_HI;

  // ****************************************
  // next values
  // ****************************************
  assign nxt_cnt = !step ? cnt_ff : clr_hit ? '0 : cnt_ff + 1'b1;
  always_comb begin
    nxt_wave = wave_ff;
    if (!ch.run) begin
      nxt_wave = lvl;  // initial level while stopped
    end else if (pwm) begin
      // invalid pwm settings freeze the pin rather than glitch it
      if (pwm_ok && match[0]) begin
        nxt_wave = !lvl;
      end else if (pwm_ok && clr_hit) begin
        nxt_wave = lvl;
      end
    end else if (match[0]) begin
      case (ch.ioa[1:0])
        ACT_HOLD: nxt_wave = lvl;
        ACT_ZERO: nxt_wave = 1'b0;
        ACT_ONE: nxt_wave = 1'b1;
        default: nxt_wave = !wave_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      wave_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      wave_ff <= nxt_wave;
    end
  end
  assign ch.cnt = cnt_ff;
  assign ch.wave = wave_ff;

  // ****************************************
  // checks
  // ****************************************
  sequence s_plain_step;
    step && !clr_hit;
  endsequence
  cnt_incr_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_plain_step |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("counter did not step by one");
  clr_ab_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ch.clr_sel == CLR_A && match[0]) || (ch.clr_sel == CLR_B && match[1]) |=> cnt_ff == '0)
    else $error("a/b match did not clear counter");
  clr_cd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ch.clr_sel == CLR_C && match[2]) || (ch.clr_sel == CLR_D && match[3]) |=> cnt_ff == '0)
    else $error("c/d match did not clear counter");
  clr_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    step && (ch.clr_sel == 3'h0 || ch.clr_sel == 3'h4) |=> cnt_ff != '0 || $past(cnt_ff) == 16'hFFFF)
    else $error("counter cleared with clearing disabled");
  stop_lvl_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !ch.run ##1 !ch.run |-> wave_ff == $past(lvl))
    else $error("stopped pin not at initial level");
  pwm_edge_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ch.run && pwm && pwm_ok && match[0] |=> wave_ff == !$past(lvl))
    else $error("pwm pin did not flip on a match");

endmodule : tpucc_chan

// File: src/tpucc_top.sv
// count clock prescale, edge select and clear control for four timer channels, apb slave
//
// Function
// - four channels, each with one wave pin from compare or pwm on register a
// - count control bits 15..8 read zero and ignore writes
// - clear code 001 clears on match a, 010 on match b
// - clear code 101 clears on match c, 110 on match d
// - codes 000 and 100 never clear; 011 and 111 must not be programmed
// - edge code 00 rising, 01 falling, 1x both edges
// - both edges halve the period; with undivided clock it is not done
// - prescale codes 000..011 pick divide by 1, 4, 16, 64
// - every channel picks its count clock on its own
// - mode 000 normal, 010 pwm, other codes prohibited
// - pin action sets initial level and 0, 1 or toggle on match a
module tpucc_top (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpucc_pkg::ADDR_W-1:0] paddr,
  input wire logic [tpucc_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [tpucc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // wave pins
  output logic chan0_wave_out,
  output logic chan1_wave_out,
  output logic chan2_wave_out,
  output logic chan3_wave_out
);
  import tpucc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [DIV_W-1:0] div_ff;
  logic [NCH-1:0] run_ff;
  logic [CTRL_IMPL_W-1:0] ctrl_ff [NCH];
  logic [2:0] mode_ff [NCH];
  logic [2:0] ioa_ff [NCH];
  logic [CNT_W-1:0] gr_ff [NCH][NGR];
  logic [DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [NCH-1:0] wave_w;
  logic [CNT_W-1:0] cnt_w [NCH];
  logic [NCH-1:0] tick_w;
  logic [DATA_W-1:0] ch_rd [NCH];

  // ****************************************
  // address decode
  // ****************************************
  wire setup = psel && !penable;
  wire done = psel && penable && pready_ff;
  wire in_ch = paddr[ADDR_W-1:REGION_LSB] == '0;
  wire [1:0] ch_sel = paddr[REGION_LSB-1:CH_LSB];
  wire [2:0] idx = paddr[CH_LSB-1:IDX_LSB];
  wire is_run = paddr == RUN_ADDR;
  wire addr_ok = (in_ch && paddr[IDX_LSB-1:0] == '0) || is_run;
  wire wr_en = done && pwrite && addr_ok;
  wire [DATA_W-1:0] rd_word = is_run ? DATA_W'(run_ff) : in_ch ? ch_rd[ch_sel] : '0;

  // ****************************************
  // shared prescaler
  // ****************************************
  // one divider for all channels keeps equal settings in phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // ****************************************
  // run control
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_ff <= '0;
    end else if (wr_en && is_run && pstrb[0]) begin
      run_ff <= pwdata[NCH-1:0];
    end
  end

  // ****************************************
  // channels
  // ****************************************
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tpucc_ch_if chif ();
    wire wr_g = wr_en && in_ch && ch_sel == 2'(g);
    wire [2:0] psc = ctrl_ff[g][PSC_LSB +: 3];
    wire [1:0] edg = ctrl_ff[g][EDGE_LSB +: 2];

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        ctrl_ff[g] <= '0;
        mode_ff[g] <= '0;
        ioa_ff[g] <= '0;
        for (int i = 0; i < NGR; i++) begin
          gr_ff[g][i] <= '0;
        end
      end else if (wr_g) begin
        case (idx)
          IDX_CTRL: if (pstrb[0]) ctrl_ff[g] <= pwdata[CTRL_IMPL_W-1:0];
          IDX_MODE: if (pstrb[0]) mode_ff[g] <= pwdata[2:0];
          IDX_IOC: if (pstrb[0]) ioa_ff[g] <= pwdata[2:0];
          IDX_CNT: ;
          default: gr_ff[g][idx[1:0]] <= tpucc_merge16(gr_ff[g][idx[1:0]], pwdata, pstrb);
        endcase
      end
    end

    // each channel decodes its own prescale and edge fields
    assign tick_w[g] = tpucc_tick(psc, edg, div_ff);
    assign chif.tick = tick_w[g];
    assign chif.run = run_ff[g];
    assign chif.clr_sel = ctrl_ff[g][CLR_LSB +: 3];
    assign chif.mode = mode_ff[g];
    assign chif.ioa = ioa_ff[g];
    for (genvar i = 0; i < NGR; i++) begin : g_gr
      assign chif.gr[i] = gr_ff[g][i];
    end
    assign cnt_w[g] = chif.cnt;
    assign wave_w[g] = chif.wave;

    // upper control bits are never stored, so they read as zero
    assign ch_rd[g] = idx == IDX_CTRL ? DATA_W'(ctrl_ff[g])
                    : idx == IDX_MODE ? DATA_W'(mode_ff[g])
                    : idx == IDX_IOC ? DATA_W'(ioa_ff[g])
                    : idx == IDX_CNT ? DATA_W'(cnt_w[g])
                    : DATA_W'(gr_ff[g][idx[1:0]]);

    tpucc_chan u_chan (
      .mclk(mclk),
      .arst_n(arst_n),
      .ch(chif.chan)
    );

    rise_16_a: assert property (@(posedge mclk) disable iff (!arst_n)
      tick_w[g] && psc == PSC_16 && edg == EDGE_RISE |-> div_ff[TAP_16:0] == 4'h7)
      else $error("rising count off the divide-16 rising edge");
    fall_16_a: assert property (@(posedge mclk) disable iff (!arst_n)
      tick_w[g] && psc == PSC_16 && edg == EDGE_FALL |-> div_ff[TAP_16:0] == 4'hF)
      else $error("falling count off the divide-16 falling edge");
    psc_64_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psc == PSC_64 && !edg[EDGE_BOTH_BIT] && tick_w[g] |=>
        (!tick_w[g])[*8] ##0 div_ff[TAP_64:0] != 6'h1F)
      else $error("divide-64 count came too soon");
    both_4_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psc == PSC_4 && edg[EDGE_BOTH_BIT] && tick_w[g] && !wr_g |=> !tick_w[g] ##1 tick_w[g])
      else $error("both-edge divide-4 not every second cycle");
    full_1_a: assert property (@(posedge mclk) disable iff (!arst_n)
      psc == PSC_1 |-> tick_w[g])
      else $error("undivided clock missed a count");
  end

  // ****************************************
  // apb answer: pready one cycle after setup, prdata from setup
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !addr_ok;
      if (setup) begin
        prdata_ff <= pwrite ? '0 : rd_word;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign chan0_wave_out = wave_w[0];
  assign chan1_wave_out = wave_w[1];
  assign chan2_wave_out = wave_w[2];
  assign chan3_wave_out = wave_w[3];

  // ****************************************
  // checks
  // ****************************************
  ctrl_rsv_a: assert property (@(posedge mclk) disable iff (!arst_n)
    done && !pwrite && in_ch && idx == IDX_CTRL |-> prdata_ff[DATA_W-1:CTRL_IMPL_W] == '0)
    else $error("control upper bits not zero");
  apb_wait_a: assert property (@(posedge mclk) disable iff (!arst_n)
    setup |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one cycle after setup");

endmodule : tpucc_top

// File: sim/tb_tpucc.sv
// self-checking bench for the timer clock and clear control block
module tb_tpucc;
  timeunit 1ns;
  timeprecision 100ps;
  import tpucc_pkg::*;

  // ****************************************
  // stimulus and design
  // ****************************************
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] wave;
  int errors = 0;
  int compares = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end

  tpucc_top i_tpucc_top (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan0_wave_out(wave[0]), .chan1_wave_out(wave[1]),
    .chan2_wave_out(wave[2]), .chan3_wave_out(wave[3])
  );

  // ****************************************
  // report and compare
  // ****************************************
  task automatic print_verdict;
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check32

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // ****************************************
  // apb master
  // ****************************************
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                          input logic [3:0] strb, output logic [31:0] rd, output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= strb;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // pready, data and error are all taken at the rising edge that ends the access
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      print_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb_xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, 4'hF, r, e);
    check_bit(e, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb_xfer(1'b0, a, 32'h0, 4'h0, d, e);
    check_bit(e, 1'b0);
  endtask : rd

  function automatic logic [11:0] ra(input int c, input logic [2:0] idx);
    ra = 12'((c << CH_LSB) | (int'(idx) << IDX_LSB));
  endfunction : ra

  // two counter samples exactly 256 cycles apart while the channel runs
  task automatic measure(input int c, input logic [15:0] ctl, output logic [15:0] c1,
                         output logic [15:0] c2);
    logic [31:0] d;
    wr(ra(c, IDX_CTRL), {16'h0, ctl});
    wr(RUN_ADDR, 32'(1 << c));
    rd(ra(c, IDX_CNT), d);
    c1 = d[15:0];
    repeat (253) @(posedge mclk);
    rd(ra(c, IDX_CNT), d);
    c2 = d[15:0];
    wr(RUN_ADDR, 32'h0);
  endtask : measure

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] d;
    logic e;
    logic [15:0] c1;
    logic [15:0] c2;
    int ch [4];
    logic [2:0] clr [6];
    int g;
    int exp;
    ch = '{0, 2, 3, 0};
    clr = '{CLR_A, CLR_B, CLR_C, CLR_D, 3'h0, 3'h4}; // 011 and 111 never programmed
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    // control registers: reset value, upper byte reads zero, channels independent
    for (int c = 0; c < NCH; c++) begin
      rd(ra(c, IDX_CTRL), d);
      check32(d, 32'h0);
      wr(ra(c, IDX_CTRL), 32'hFFFF_FF00 | 32'(8'h5A ^ 8'(c * 8)));
    end
    for (int c = 0; c < NCH; c++) begin
      rd(ra(c, IDX_CTRL), d);
      check32(d, 32'(8'h5A ^ 8'(c * 8)));
    end
    // upper lane alone must leave the register untouched
    apb_xfer(1'b1, ra(1, IDX_CTRL), 32'h0000_FF00, 4'h2, d, e);
    rd(ra(1, IDX_CTRL), d);
    check32(d, 32'h52);
    wr(ra(0, IDX_MODE), 32'(MODE_PWM));
    rd(ra(0, IDX_MODE), d);
    check32(d, 32'(MODE_PWM));
    wr(ra(0, IDX_MODE), 32'(MODE_NORMAL));
    // holes in the map answer with an error, and with zero data outside the channel region
    apb_xfer(1'b0, 12'h0F0, 32'h0, 4'h0, d, e);
    check_bit(e, 1'b1);
    check32(d, 32'h0);
    apb_xfer(1'b0, 12'h002, 32'h0, 4'h0, d, e);
    check_bit(e, 1'b1);
    // stopped channel pin follows the level bit of its pin action
    for (int c = 0; c < NCH; c++) begin
      wr(ra(c, IDX_IOC), 32'h4);
      repeat (2) @(posedge mclk);
      check_bit(wave[c], 1'b1);
      wr(ra(c, IDX_IOC), 32'h0);
      repeat (2) @(posedge mclk);
      check_bit(wave[c], 1'b0);
    end
    // prescale and edge: ticks in a 256-cycle window
    for (int p = 0; p < 4; p++) begin
      for (int eg = 0; eg < 3; eg++) begin
        measure(ch[p], 16'((eg << EDGE_LSB) | p), c1, c2); // prescale stays below 100
        exp = (p == 0) ? 256 : ((256 >> (2 * p)) << (eg >> 1));
        check32(32'(c2 - c1), 32'(exp));
      end
    end
    // clear sources on channel 1, compare values rising so the counter never overshoots
    for (int i = 0; i < NGR; i++) begin
      wr(ra(1, 3'(4 + i)), 32'(20 + 10 * i));
    end
    for (int k = 0; k < 6; k++) begin
      g = (k < 4) ? 20 + 10 * k : 0;
      measure(1, 16'(clr[k]) << CLR_LSB, c1, c2);
      if (g > 0) begin
        check_bit(c1 <= 16'(g), 1'b1);
        check32(32'(c2), 32'((int'(c1) + 256) % (g + 1)));
      end else begin
        check32(32'(16'(c2 - c1)), 32'd256);
      end
    end
    // pin action on a register a match while running: normal 1-then-0, pwm 0-then-1
    for (int k = 0; k < 2; k++) begin
      wr(ra(3, IDX_MODE), (k == 1) ? 32'(MODE_PWM) : 32'(MODE_NORMAL));
      wr(ra(3, IDX_CTRL), 32'(PSC_1));
      wr(ra(3, IDX_IOC), (k == 1) ? 32'h2 : 32'h5);
      rd(ra(3, IDX_CNT), d);
      wr(ra(3, 3'h4), d + 32'd30);
      wr(RUN_ADDR, 32'h8);
      repeat (60) @(posedge mclk);
      check_bit(wave[3], (k == 1) ? 1'b1 : 1'b0);
      wr(RUN_ADDR, 32'h0);
    end
    print_verdict();
  end
endmodule : tb_tpucc
